// [rtl/actuator_bus_input_decoder.v]
/*
 Input register decoder of a valve actuator on an industrial Ethernet link.
 Assumes a protocol front end that delivers one register access at a time
 as a request strobe with function code, register index and data word.
 All inputs come from logic on the same clock except the local selector
 mode, which is a pin and is synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none
`include "act_input_regs.vh"

// Contract
// - Address settings change restarts protocol stack
// - Swap selected: exchange low and high bytes
// - Writes by functions 6 and 16
// - Function 3 reads back register contents
// - Set point uses low ten bits
// - Bit 0 opens, remote only
// - Bit 1 closes, remote only
// - Bit 2 stops, remote only
// - Bit 3 urgent open, any mode
// - Bit 4 urgent shut, any mode
// - Bit 5 blocks drive in all modes
// - Bit 7 toggle feeds bus watchdog
// - Timeout 0.0 to 10.0 s, zero disables
// - Bit 6 disables positioner in remote
// - Swap setting is 0 or 1
module actuator_bus_input_decoder #(
    parameter integer TENTH_CYCLES = `TENTH_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Register access from the protocol front end
    input wire req_valid,
    input wire [7:0] req_function,
    input wire [15:0] req_index,
    input wire [15:0] req_wdata,
    output reg resp_valid_reg,
    output reg resp_error_reg,
    output reg [15:0] resp_rdata_reg,
    // Device settings
    input wire [1:0] address_assign_mode,
    input wire [31:0] fixed_address,
    input wire [31:0] netmask,
    input wire byte_order_swap_select,
    input wire [6:0] toggle_timeout_setting,
    input wire [3:0] bus_fault_reaction,
    input wire link_fault,
    input wire fault_ack,
    // Operating mode pin: high is remote
    input wire remote_mode_pin,
    // Drive outputs
    output reg [9:0] position_reg,
    output reg drive_open_reg,
    output reg drive_shut_reg,
    output reg drive_stop_reg,
    output reg urgent_drive_open_reg,
    output reg urgent_drive_shut_reg,
    output reg emergency_position_reg,
    output reg fail_safe_reg,
    output reg drive_blocked_reg,
    output reg positioner_off_reg,
    output reg watchdog_fault_reg,
    output reg bus_fault_reg,
    output reg stack_restart_reg
);

    // ==========================================================
    // Declarations
    reg [15:0] position_setpoint_reg;
    reg [15:0] drive_command_bits_reg;
    reg swap_reg;
    reg [6:0] timeout_reg;
    reg [3:0] reaction_reg;
    reg [2:0] remote_sync_reg;
    reg remote_reg;
    reg [1:0] mode_seen_reg;
    reg [31:0] addr_seen_reg;
    reg [31:0] mask_seen_reg;
    reg settings_primed_reg;
    reg [4:0] restart_count_reg;
    reg [15:0] last_setpoint_reg;
    reg [15:0] last_command_reg;
    wire [15:0] wdata_host;
    wire [15:0] rdata_host;
    wire [15:0] rdata_bus;
    wire is_write;
    wire is_read;
    wire index_ok;
    wire wd_fault;
    wire any_fault;
    wire addr_changed;
    wire [15:0] cmd_eff;
    wire [15:0] sp_eff;

    assign is_write = (req_function == `FN_WRITE_SINGLE)
                      || (req_function == `FN_WRITE_MULTI);
    assign is_read = (req_function == `FN_READ_HOLD);
    assign index_ok = (req_index == `SETPOINT_IDX) || (req_index == `COMMAND_IDX);
    assign rdata_host = (req_index == `SETPOINT_IDX) ? position_setpoint_reg
                                                      : drive_command_bits_reg;

    // ==========================================================
    // Byte order on both directions of the link
    byte_lane_swap u_swap_in (
        .swap_en(swap_reg),
        .word_in(req_wdata),
        .word_out(wdata_host)
    );

    byte_lane_swap u_swap_out (
        .swap_en(swap_reg),
        .word_in(rdata_host),
        .word_out(rdata_bus)
    );

    // ==========================================================
    // Watchdog on the toggle bit of the command word
    toggle_watchdog #(
        .TENTH_CYCLES(TENTH_CYCLES)
    ) u_watchdog (
        .clock(clock),
        .rst(rst),
        .timeout_tenths(timeout_reg),
        .toggle_bit(drive_command_bits_reg[`CMD_TOGGLE_BIT]),
        .clear_fault(fault_ack),
        .fault_reg(wd_fault)
    );

    // ==========================================================
    // Settings capture
    // Swap setting is a single bit, so only 0 and 1 can exist
    always @(posedge clock) begin
        if (rst) begin
            swap_reg <= `SWAP_RESET;
            timeout_reg <= `TIMEOUT_RESET;
            reaction_reg <= `REACTION_RESET;
        end else begin
            swap_reg <= byte_order_swap_select;
            // Beyond 10.0 s the timeout is held at its top
            if (toggle_timeout_setting > `TIMEOUT_MAX)
                timeout_reg <= `TIMEOUT_MAX;
            else
                timeout_reg <= toggle_timeout_setting;
            // Codes above 8 fall back to ignore
            if (bus_fault_reaction > `REACT_FAIL_SAFE)
                reaction_reg <= `REACT_IGNORE;
            else
                reaction_reg <= bus_fault_reaction;
        end
    end

    // ==========================================================
    // Mode pin synchroniser; change counts once stages two and three agree
    always @(posedge clock) begin
        if (rst) begin
            remote_sync_reg <= 3'h0;
            remote_reg <= 1'b0;
        end else begin
            remote_sync_reg <= {remote_sync_reg[1:0], remote_mode_pin};
            if (remote_sync_reg[1] == remote_sync_reg[2])
                remote_reg <= remote_sync_reg[2];
        end
    end

    // ==========================================================
    // Stack restart on a change of address settings
    // First cycle after reset only records, so reset alone triggers nothing
    assign addr_changed = settings_primed_reg
                          && (mode_seen_reg != address_assign_mode
                              || addr_seen_reg != fixed_address
                              || mask_seen_reg != netmask);

    always @(posedge clock) begin
        if (rst) begin
            mode_seen_reg <= 2'h0;
            addr_seen_reg <= 32'h0000_0000;
            mask_seen_reg <= 32'h0000_0000;
            settings_primed_reg <= 1'b0;
            restart_count_reg <= 5'h00;
            stack_restart_reg <= 1'b0;
        end else begin
            mode_seen_reg <= address_assign_mode;
            addr_seen_reg <= fixed_address;
            mask_seen_reg <= netmask;
            settings_primed_reg <= 1'b1;
            if (addr_changed) begin
                restart_count_reg <= `STACK_RESTART_CYCLES;
                stack_restart_reg <= 1'b1;
            end else if (restart_count_reg != 5'h00) begin
                restart_count_reg <= restart_count_reg - 5'h01;
                stack_restart_reg <= (restart_count_reg != 5'h01);
            end else begin
                stack_restart_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Register access; a restart of the stack refuses requests
    always @(posedge clock) begin
        if (rst) begin
            position_setpoint_reg <= `SETPOINT_RESET;
            drive_command_bits_reg <= `COMMAND_RESET;
            resp_valid_reg <= 1'b0;
            resp_error_reg <= 1'b0;
            resp_rdata_reg <= 16'h0000;
        end else begin
            resp_valid_reg <= req_valid;
            resp_error_reg <= 1'b0;
            if (req_valid) begin
                if (stack_restart_reg || !index_ok || !(is_write || is_read)) begin
                    resp_error_reg <= 1'b1;
                    resp_rdata_reg <= 16'h0000;
                end else if (is_write) begin
                    if (req_index == `SETPOINT_IDX)
                        position_setpoint_reg <= wdata_host;
                    else
                        drive_command_bits_reg <= wdata_host;
                    resp_rdata_reg <= req_wdata;
                end else begin
                    resp_rdata_reg <= rdata_bus;
                end
            end
        end
    end

    // ==========================================================
    // Last valid values, frozen while the bus is in fault
    assign any_fault = wd_fault | link_fault;

    always @(posedge clock) begin
        if (rst) begin
            last_setpoint_reg <= `SETPOINT_RESET;
            last_command_reg <= `COMMAND_RESET;
            bus_fault_reg <= 1'b0;
            watchdog_fault_reg <= 1'b0;
        end else begin
            bus_fault_reg <= any_fault;
            watchdog_fault_reg <= wd_fault;
            if (!any_fault) begin
                last_setpoint_reg <= position_setpoint_reg;
                last_command_reg <= drive_command_bits_reg;
            end
        end
    end

    // Hold last valid keeps the frozen words; other reactions use live ones
    assign cmd_eff = (any_fault && reaction_reg == `REACT_LAST_VALID)
                     ? last_command_reg : drive_command_bits_reg;
    assign sp_eff = (any_fault && reaction_reg == `REACT_LAST_VALID)
                    ? last_setpoint_reg : position_setpoint_reg;

    // ==========================================================
    // Drive decode
    // Block beats everything; urgent moves work in local too
    always @(posedge clock) begin
        if (rst) begin
            position_reg <= 10'h000;
            drive_open_reg <= 1'b0;
            drive_shut_reg <= 1'b0;
            drive_stop_reg <= 1'b0;
            urgent_drive_open_reg <= 1'b0;
            urgent_drive_shut_reg <= 1'b0;
            emergency_position_reg <= 1'b0;
            fail_safe_reg <= 1'b0;
            drive_blocked_reg <= 1'b0;
            positioner_off_reg <= 1'b0;
        end else begin
            // Upper reserved bits are dropped, not checked
            position_reg <= sp_eff[`SETPOINT_WIDTH-1:0];
            drive_blocked_reg <= cmd_eff[`CMD_BLOCK_BIT];
            positioner_off_reg <= remote_reg && cmd_eff[`CMD_POS_OFF_BIT];
            drive_open_reg <= 1'b0;
            drive_shut_reg <= 1'b0;
            drive_stop_reg <= 1'b0;
            urgent_drive_open_reg <= 1'b0;
            urgent_drive_shut_reg <= 1'b0;
            emergency_position_reg <= 1'b0;
            fail_safe_reg <= 1'b0;
            if (cmd_eff[`CMD_BLOCK_BIT]) begin
                drive_stop_reg <= 1'b1;
            end else if (any_fault && reaction_reg != `REACT_IGNORE
                         && reaction_reg != `REACT_LAST_VALID) begin
                case (reaction_reg)
                    `REACT_STOP: drive_stop_reg <= 1'b1;
                    `REACT_OPEN: drive_open_reg <= 1'b1;
                    `REACT_CLOSE: drive_shut_reg <= 1'b1;
                    `REACT_EMERG_POS: emergency_position_reg <= 1'b1;
                    `REACT_EMERG_OPEN: urgent_drive_open_reg <= 1'b1;
                    `REACT_EMERG_CLOSE: urgent_drive_shut_reg <= 1'b1;
                    `REACT_FAIL_SAFE: fail_safe_reg <= 1'b1;
                    default: drive_stop_reg <= 1'b1;
                endcase
            end else if (cmd_eff[`CMD_URG_OPEN_BIT]) begin
                urgent_drive_open_reg <= 1'b1;
            end else if (cmd_eff[`CMD_URG_SHUT_BIT]) begin
                urgent_drive_shut_reg <= 1'b1;
            end else if (remote_reg) begin
                // Stop outranks open and close when several are set
                if (cmd_eff[`CMD_STOP_BIT])
                    drive_stop_reg <= 1'b1;
                else if (cmd_eff[`CMD_OPEN_BIT] && !cmd_eff[`CMD_CLOSE_BIT])
                    drive_open_reg <= 1'b1;
                else if (cmd_eff[`CMD_CLOSE_BIT] && !cmd_eff[`CMD_OPEN_BIT])
                    drive_shut_reg <= 1'b1;
                else if (cmd_eff[`CMD_OPEN_BIT])
                    drive_stop_reg <= 1'b1;
            end
        end
    end

endmodule
`default_nettype wire

// [rtl/act_input_regs.vh]
/*
 Constants for the actuator fieldbus input register decoder.
 Assumes inclusion by bare name from the design files under rtl/.
*/
`ifndef ACT_INPUT_REGS_VH
`define ACT_INPUT_REGS_VH

// ==========================================================
// Register indices (word addresses on the register port)
`define SETPOINT_IDX 16'h0000
`define COMMAND_IDX 16'h0001
// ==========================================================
// Function codes of the link
`define FN_READ_HOLD 8'h03
`define FN_WRITE_SINGLE 8'h06
`define FN_WRITE_MULTI 8'h10
// ==========================================================
// Field positions of the command word
`define CMD_OPEN_BIT 0
`define CMD_CLOSE_BIT 1
`define CMD_STOP_BIT 2
`define CMD_URG_OPEN_BIT 3
`define CMD_URG_SHUT_BIT 4
`define CMD_BLOCK_BIT 5
`define CMD_POS_OFF_BIT 6
`define CMD_TOGGLE_BIT 7
`define SETPOINT_WIDTH 10
// ==========================================================
// Reset values
`define SETPOINT_RESET 16'h0000
`define COMMAND_RESET 16'h0000
`define TIMEOUT_RESET 7'h00
`define SWAP_RESET 1'b0
`define REACTION_RESET 4'h0
// ==========================================================
// Timing: timeout setting counts tenths of a second
`define TENTH_SECOND_NS 100000000
`define CLOCK_PERIOD_NS 10
`define TENTH_CYCLES (`TENTH_SECOND_NS / `CLOCK_PERIOD_NS)
`define TIMEOUT_MAX 7'h64
`define STACK_RESTART_CYCLES 5'h10
// ==========================================================
// Fault reaction codes
`define REACT_IGNORE 4'h0
`define REACT_STOP 4'h1
`define REACT_OPEN 4'h2
`define REACT_CLOSE 4'h3
`define REACT_EMERG_POS 4'h4
`define REACT_EMERG_OPEN 4'h5
`define REACT_EMERG_CLOSE 4'h6
`define REACT_LAST_VALID 4'h7
`define REACT_FAIL_SAFE 4'h8

`endif

// [rtl/byte_lane_swap.v]
/*
 Optional exchange of the two bytes of a 16-bit register word.
 Assumes a pure combinational use; the select is a registered level.
*/
`timescale 1ns/1ns
`default_nettype none

module byte_lane_swap (
    // Control
    input wire swap_en,
    // Data
    input wire [15:0] word_in,
    output wire [15:0] word_out
);

    // ==========================================================
    // Swap
    // Low byte 0..7 trades places with high byte 8..15
    assign word_out = swap_en ? {word_in[7:0], word_in[15:8]} : word_in;

endmodule
`default_nettype wire

// [rtl/toggle_watchdog.v]
/*
 Bus watchdog that expects the master's liveness bit to flip in time.
 Assumes the toggle bit arrives as a registered level on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "act_input_regs.vh"

module toggle_watchdog #(
    parameter integer TENTH_CYCLES = `TENTH_CYCLES
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Settings and observed bit
    input wire [6:0] timeout_tenths,
    input wire toggle_bit,
    input wire clear_fault,
    // Result
    output reg fault_reg
);

    reg toggle_last_reg;
    reg [31:0] tick_reg;
    reg [6:0] tenths_reg;
    wire flipped;
    wire tick_done;

    assign flipped = toggle_bit ^ toggle_last_reg;
    assign tick_done = (tick_reg == TENTH_CYCLES - 1);

    // ==========================================================
    // Timer
    // Any flip restarts the whole interval; zero disables the monitor
    always @(posedge clock) begin
        if (rst) begin
            toggle_last_reg <= 1'b0;
            tick_reg <= 32'h0000_0000;
            tenths_reg <= 7'h00;
            fault_reg <= 1'b0;
        end else begin
            toggle_last_reg <= toggle_bit;
            if (timeout_tenths == 7'h00 || flipped) begin
                tick_reg <= 32'h0000_0000;
                tenths_reg <= 7'h00;
            end else if (tick_done) begin
                tick_reg <= 32'h0000_0000;
                if (tenths_reg != 7'h7f)
                    tenths_reg <= tenths_reg + 7'h01;
            end else begin
                tick_reg <= tick_reg + 32'h0000_0001;
            end
            // Expiry sets, and it wins over a clear in the same cycle
            if (timeout_tenths != 7'h00 && !flipped && tick_done
                    && tenths_reg + 7'h01 >= timeout_tenths)
                fault_reg <= 1'b1;
            else if (clear_fault || timeout_tenths == 7'h00)
                fault_reg <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// [testbench/decoder_checker_assertions.sv]
/* Concurrent checks on the ports of the input register decoder.
 Assumes binding to the decoder top; settings held steady in reset. */
`timescale 1ns/1ns
`default_nettype none
module decoder_checker #(
    parameter integer TENTH_CYCLES = 10
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Requests and answers
    input wire logic req_valid,
    input wire logic [7:0] req_function,
    input wire logic [15:0] req_index,
    input wire logic [15:0] req_wdata,
    input wire logic resp_valid_reg,
    input wire logic resp_error_reg,
    // Settings
    input wire logic [1:0] address_assign_mode,
    input wire logic byte_order_swap_select,
    input wire logic [6:0] toggle_timeout_setting,
    input wire logic link_fault,
    input wire logic remote_mode_pin,
    // Drive outputs
    input wire logic [9:0] position_reg,
    input wire logic drive_open_reg,
    input wire logic drive_shut_reg,
    input wire logic drive_stop_reg,
    input wire logic urgent_drive_open_reg,
    input wire logic urgent_drive_shut_reg,
    input wire logic drive_blocked_reg,
    input wire logic watchdog_fault_reg,
    input wire logic bus_fault_reg,
    input wire logic stack_restart_reg
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // ==========================================================
    // Plain accepted writes; swap and faults left out to keep timing exact
    wire wr_ok = req_valid && !stack_restart_reg && !bus_fault_reg && !byte_order_swap_select
        && (req_function == 8'h06 || req_function == 8'h10);
    wire wr0 = wr_ok && req_index == 16'h0000;
    wire wr1 = wr_ok && req_index == 16'h0001;
    // ==========================================================
    // Checks
    chk_resp_timing: assert property (req_valid |=> resp_valid_reg)
        else $error("no response after request");
    chk_resp_cause: assert property (resp_valid_reg |-> $past(req_valid))
        else $error("response without request");
    chk_bad_func: assert property (
        req_valid && !(req_function inside {8'h03, 8'h06, 8'h10}) |=> resp_error_reg)
        else $error("bad function accepted");
    chk_restart_refuse: assert property (stack_restart_reg && req_valid |=> resp_error_reg)
        else $error("request accepted during restart");
    chk_restart_start: assert property (
        $changed(address_assign_mode) |-> ##[1:2] stack_restart_reg)
        else $error("no restart after mode change");
    chk_position_bits: assert property (
        wr0 |=> ##1 position_reg == $past(req_wdata[9:0], 2))
        else $error("position not low ten bits");
    chk_block_cmd: assert property (wr1 && req_wdata[5] |=> ##1 drive_blocked_reg)
        else $error("block bit not applied");
    chk_block_quiet: assert property (
        drive_blocked_reg |-> !(drive_open_reg || drive_shut_reg
        || urgent_drive_open_reg || urgent_drive_shut_reg)) else $error("blocked drive moves");
    chk_urgent_open: assert property (
        wr1 && req_wdata[3] && !req_wdata[5] |=> ##1 urgent_drive_open_reg)
        else $error("urgent open ignored");
    // Without a bus fault, a stop in local may only come from the block bit
    chk_local_idle: assert property (
        (!remote_mode_pin && !bus_fault_reg)[*6] |-> !(drive_open_reg || drive_shut_reg
        || (drive_stop_reg && !drive_blocked_reg)))
        else $error("remote command acted on in local");
    chk_link_fault: assert property (link_fault |=> bus_fault_reg)
        else $error("link fault not flagged");
    // Setting, watchdog and output flop each add one cycle
    chk_wd_off: assert property (
        (toggle_timeout_setting == 7'h00)[*4] |-> !watchdog_fault_reg)
        else $error("watchdog active at zero timeout");
endmodule
bind actuator_bus_input_decoder decoder_checker #(.TENTH_CYCLES(TENTH_CYCLES)) i_chk (.*);
`default_nettype wire

// [testbench/net_master_model.sv]
/* Network master model issuing one register access at a time.
 Assumes the decoder answers one cycle after it takes a request. */
`timescale 1ns/1ns
`default_nettype none
module net_master_model (
    // Clock
    input wire logic clock,
    // Requests
    output logic req_valid,
    output logic [7:0] req_function,
    output logic [15:0] req_index,
    output logic [15:0] req_wdata,
    // Answers
    input wire logic resp_valid_reg,
    input wire logic resp_error_reg,
    input wire logic [15:0] resp_rdata_reg
);
    // ==========================================================
    // Idle bus
    initial begin
        req_valid = 1'b0;
        req_function = 8'h00;
        req_index = 16'h0000;
        req_wdata = 16'h0000;
    end
    // Index is the device numbering, no master offset; words go unchanged, endian fixed
    task automatic access(input logic [7:0] fn, input logic [15:0] idx,
            input logic [15:0] wd, output logic [15:0] rd, output logic err);
        @(negedge clock);
        req_valid = 1'b1;
        req_function = fn;
        req_index = idx;
        req_wdata = wd;
        @(negedge clock);
        rd = resp_valid_reg ? resp_rdata_reg : 16'hxxxx;
        err = resp_valid_reg ? resp_error_reg : 1'bx;
        // Released lines change so a stale word is never mistaken for data
        req_valid = 1'b0;
        req_function = ~fn;
        req_index = ~idx;
        req_wdata = ~wd;
    endtask
endmodule
`default_nettype wire

// [testbench/actuator_bus_input_decoder_tb.sv]
/* Self-checking bench for the input register decoder.
 Assumes the master model and the bound checker beside it. */
`timescale 1ns/1ns
`default_nettype none
module actuator_bus_input_decoder_tb;
    localparam integer TENTH = 10;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [1:0] mode = 2'h0;
    logic [31:0] addr = 32'h00000000;
    logic [31:0] mask = 32'h00000000;
    logic swap = 1'b0;
    logic [6:0] timeout = 7'h00;
    logic [3:0] reaction = 4'h0;
    logic link_fault = 1'b0;
    logic fault_ack = 1'b0;
    logic remote = 1'b1;
    logic [15:0] rd;
    logic er;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [6:0] react_exp [0:8] = '{7'h00, 7'h04, 7'h01, 7'h02, 7'h20, 7'h08, 7'h10, 7'h00, 7'h40};
    wire req_valid;
    wire [7:0] req_function;
    wire [15:0] req_index;
    wire [15:0] req_wdata;
    wire resp_valid_reg;
    wire resp_error_reg;
    wire [15:0] resp_rdata_reg;
    wire [9:0] position_reg;
    wire [6:0] drv;
    wire [4:0] misc;
    // ==========================================================
    // Clock, master and decoder
    always #5 clock = ~clock;
    net_master_model m (.clock(clock), .req_valid(req_valid), .req_function(req_function),
        .req_index(req_index), .req_wdata(req_wdata), .resp_valid_reg(resp_valid_reg),
        .resp_error_reg(resp_error_reg), .resp_rdata_reg(resp_rdata_reg));
    actuator_bus_input_decoder #(.TENTH_CYCLES(TENTH)) i_dut (.clock(clock), .rst(rst),
        .req_valid(req_valid), .req_function(req_function), .req_index(req_index),
        .req_wdata(req_wdata), .resp_valid_reg(resp_valid_reg), .resp_error_reg(resp_error_reg),
        .resp_rdata_reg(resp_rdata_reg), .address_assign_mode(mode), .fixed_address(addr),
        .netmask(mask), .byte_order_swap_select(swap), .toggle_timeout_setting(timeout),
        .bus_fault_reaction(reaction), .link_fault(link_fault), .fault_ack(fault_ack),
        .remote_mode_pin(remote), .position_reg(position_reg), .drive_open_reg(drv[0]),
        .drive_shut_reg(drv[1]), .drive_stop_reg(drv[2]), .urgent_drive_open_reg(drv[3]),
        .urgent_drive_shut_reg(drv[4]), .emergency_position_reg(drv[5]),
        .fail_safe_reg(drv[6]), .drive_blocked_reg(misc[0]), .positioner_off_reg(misc[1]),
        .watchdog_fault_reg(misc[2]), .bus_fault_reg(misc[3]), .stack_restart_reg(misc[4]));
    // ==========================================================
    // Helpers
    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic req(input logic [7:0] fn, input logic [15:0] idx, input logic [15:0] wd);
        m.access(fn, idx, wd, rd, er);
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic summarize;
        if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, far above the roughly 300 cycles needed
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            summarize();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        settle(5);
        rst = 1'b0;
        check("idle_out", {4'h0, misc, drv}, 16'h0000);
        // Set point values keep reserved bits at zero
        req(8'h06, 16'h0000, 16'h0200);
        check("echo", rd, 16'h0200);
        req(8'h03, 16'h0000, 16'h0000);
        check("read", rd, 16'h0200);
        check("pos_half", position_reg, 16'h0200);
        req(8'h10, 16'h0000, 16'h03ff);
        settle(1);
        check("pos_full", position_reg, 16'h03ff);
        req(8'h04, 16'h0000, 16'h0000);
        check("bad_fn", er, 16'h0001);
        req(8'h06, 16'h0002, 16'h0000);
        check("bad_idx", er, 16'h0001);
        // Swap: bus word 0102 lands as 0201, reads back in bus order
        swap = 1'b1;
        settle(2);
        req(8'h06, 16'h0000, 16'h0102);
        settle(1);
        check("swap_pos", position_reg, 16'h0201);
        req(8'h03, 16'h0000, 16'h0000);
        check("swap_read", rd, 16'h0102);
        swap = 1'b0;
        settle(2);
        // Command bits 0 to 6 in remote, then in local
        for (int k = 0; k < 2; k++) begin
            remote = (k == 0);
            settle(6);
            for (int i = 0; i < 7; i++) begin
                req(8'h06, 16'h0001, 16'h0001 << i);
                settle(1);
                // Block also holds the drive stopped, in either mode
                check("cmd", {misc[1:0], drv[4:0]},
                    (i == 5) ? 16'h0024 : (k == 0 || i == 3 || i == 4) ? 16'h0001 << i : 16'h0000);
            end
        end
        remote = 1'b1;
        req(8'h06, 16'h0001, 16'h0000);
        settle(6);
        // Watchdog: no flip trips it; ack plus flips keep it quiet
        timeout = 7'h01;
        settle(3 * TENTH);
        check("wd_trip", misc[3:2], 16'h0003);
        fault_ack = 1'b1;
        for (int i = 0; i < 8; i++) begin
            req(8'h06, 16'h0001, {8'h00, ~i[0], 7'h00});
            if (i == 1) fault_ack = 1'b0;
            settle(2);
        end
        check("wd_live", misc[3:2], 16'h0000);
        timeout = 7'h00;
        settle(3 * TENTH);
        check("wd_off", misc[2], 16'h0000);
        // Every fault reaction code through an external fault
        for (int i = 0; i < 9; i++) begin
            reaction = i[3:0];
            link_fault = 1'b1;
            settle(3);
            check("react", drv, react_exp[i]);
            link_fault = 1'b0;
            settle(3);
        end
        // Each address setting restarts the stack and refuses meanwhile
        for (int i = 0; i < 3; i++) begin
            if (i == 0) mode = 2'h1;
            else if (i == 1) addr = 32'h0a000001;
            else mask = 32'hffffff00;
            settle(2);
            check("restart", misc[4], 16'h0001);
            req(8'h03, 16'h0000, 16'h0000);
            check("refused", er, 16'h0001);
            settle(20);
            check("restart_end", misc[4], 16'h0000);
        end
        summarize();
    end
endmodule
`default_nettype wire
